// ===== verilog/monitor_pkg.sv
// Constants shared by the analog monitor selector and scaler.
package monitor_pkg;
   localparam int CLK_HZ = 200000000;
   localparam int REFRESH_US = 1000;
   localparam int REFRESH_CYCLES = CLK_HZ / 1000000 * REFRESH_US;
   localparam int DAC_W = 16;
   localparam logic signed [15:0] DAC_MAX = 16'sh7FFF;
   localparam logic signed [15:0] DAC_MIN = -16'sh7FFF;
   localparam logic [15:0] DAC_MID = 16'h8000;
   localparam logic [15:0] DAC_HALF = 16'h7FFF;
   localparam int FULL_VOLTS = 10;
   // Register byte offsets.
   localparam logic [7:0] OFS_SRC1 = 8'h00;
   localparam logic [7:0] OFS_SCALE1 = 8'h04;
   localparam logic [7:0] OFS_SRC2 = 8'h08;
   localparam logic [7:0] OFS_SCALE2 = 8'h0C;
   localparam logic [7:0] OFS_METHOD = 8'h10;
   localparam logic [7:0] OFS_DIR = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_OUT = 8'h1C;
   localparam int SRC_W = 5;
   localparam int SCALE_W = 32;
   localparam logic [4:0] SRC_LAST = 5'h15;
   localparam logic [4:0] SRC_RSV_LO = 5'h10;
   localparam logic [4:0] SRC_RSV_HI = 5'h12;
   localparam logic [4:0] SRC_ENC_TEMP = 5'h13;
   localparam logic [4:0] SRC_ONE_REV = 5'h15;
   localparam logic [31:0] GAIN_SPEED = 32'd500;
   localparam logic [31:0] GAIN_PCT = 32'd33;
   localparam logic [31:0] GAIN_PULSE = 32'd3000;
   localparam logic [31:0] GAIN_BUS = 32'd80;
   localparam logic [31:0] GAIN_TEMP = 32'd10;
   localparam logic [31:0] GAIN_REV = 32'd110000;
   localparam logic [1:0] METH_BIPOLAR = 2'h0;
   localparam logic [1:0] METH_ABS = 2'h1;
   localparam logic [1:0] METH_OFFSET = 2'h2;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ===== verilog/analog_monitor.sv
// Two-channel analog monitor source selector, scaler and DAC code generator.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Two monitor channels, each with its own source select and scale setting.
// - Both channel outputs are recomputed and updated every millisecond.
// - Scale is quantity units per volt; zero scale uses the source default gain.
// - Codes 0 to 3 are speed quantities with default gain 500 per volt.
// - Codes 4, 11, 12 are torque percents with default gain 33 per volt.
// - Codes 5 to 8 are position errors in pulses, default 3000 per volt.
// - Code 9 bus voltage at 80 per volt; code 10 regeneration ratio at 33.
// - Code 13 reverse torque limit at 33; codes 14 and 15 at 500.
// - Codes 19 and 20 are temperatures at 10 per volt; 16 to 18 reserved.
// - Code 21 is one-revolution encoder position at 110000 pulses per volt.
// - Encoder temperature is meaningful only with a 20-bit incremental encoder.
// - Direction follows rotation setting, except absolute one-revolution data is CCW.
// - Incremental one-revolution position is valid only after the first index pulse.
// - Output method 0 bipolar, 1 absolute unipolar, 2 unipolar offset at mid-scale.
module analog_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [(monitor_pkg::SRC_LAST+1)*32-1:0] quantity_bus,
   input wire logic encoder_is_incremental,
   input wire logic encoder_is_20bit_inc,
   input wire logic index_pulse,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [15:0] dac_one_code,
   output logic [15:0] dac_two_code,
   output logic dac_update
);
   import monitor_pkg::*;

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CH1 = 2'b01, ST_CH2 = 2'b11} step_t;

   logic [4:0] monitor_one_source_select_r;
   logic [31:0] monitor_one_scale_r;
   logic [4:0] monitor_two_source_select_r;
   logic [31:0] monitor_two_scale_r;
   logic [1:0] monitor_output_method_r;
   logic rotation_direction_select_r;
   logic index_seen_r;
   logic [17:0] tick_cnt_r;
   step_t step_r;
   logic [15:0] dac_one_code_r;
   logic [15:0] dac_two_code_r;
   logic dac_update_r;
   logic [31:0] aw_addr_r;
   logic aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_have_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   // Default gain per source; zero marks a reserved code.
   function automatic logic [31:0] default_gain(input logic [4:0] src);
      logic [31:0] g;
      g = 32'h0;
      unique case (src) inside
         [5'h00:5'h03], 5'h0E, 5'h0F: g = GAIN_SPEED;
         5'h04, 5'h0A, 5'h0B, 5'h0C, 5'h0D: g = GAIN_PCT;
         [5'h05:5'h08]: g = GAIN_PULSE;
         5'h09: g = GAIN_BUS;
         5'h13, 5'h14: g = GAIN_TEMP;
         5'h15: g = GAIN_REV;
         default: g = 32'h0;
      endcase
      return g;
   endfunction

   // Produces the DAC code for one channel from its source, scale and the shared method.
   function automatic logic [15:0] channel_code(input logic [4:0] src,
         input logic [31:0] scale, input logic [1:0] meth, input logic dir_rev,
         input logic [(SRC_LAST+1)*32-1:0] qbus, input logic inc_enc, input logic enc20,
         input logic idx_ok);
      logic signed [31:0] raw;
      logic [31:0] gain;
      logic signed [63:0] volts_fs;
      logic signed [63:0] sat;
      logic bad;
      logic [15:0] code;
      raw = 32'sh0;
      gain = (scale == 32'h0) ? default_gain(src) : scale;
      bad = (src > SRC_LAST) || (src >= SRC_RSV_LO && src <= SRC_RSV_HI);
      if (src == SRC_ENC_TEMP && !enc20) begin
         bad = 1'b1;
      end
      if (src == SRC_ONE_REV && inc_enc && !idx_ok) begin
         bad = 1'b1;
      end
      if (!bad) begin
         raw = $signed(qbus[src*32 +: 32]);
      end
      // Absolute one-revolution data keeps CCW as positive.
      if (dir_rev && !(src == SRC_ONE_REV && !inc_enc)) begin
         raw = -raw;
      end
      if (meth == METH_ABS && raw < 0) begin
         raw = -raw;
      end
      // Full scale is ten volts, so code = raw * max / (gain * 10).
      volts_fs = (bad || gain == 32'h0) ? 64'sh0 :
            (64'(raw) * 64'(DAC_MAX)) / $signed({32'h0, gain} * 64'(FULL_VOLTS));
      if (meth == METH_OFFSET) begin
         volts_fs = volts_fs / 2;
      end
      sat = volts_fs;
      if (sat > 64'(DAC_MAX)) begin
         sat = 64'(DAC_MAX);
      end
      if (sat < 64'(DAC_MIN)) begin
         sat = 64'(DAC_MIN);
      end
      code = sat[15:0];
      if (meth != METH_BIPOLAR) begin
         // Unipolar codes are unsigned; offset mode centres on mid-scale, absolute mode doubles the magnitude from zero.
         code = (meth == METH_ABS) ? 16'(sat[15:0] << 1) : 16'(sat[15:0] + DAC_MID);
      end
      return code;
   endfunction

   wire tick = (tick_cnt_r == 18'(REFRESH_CYCLES - 1));
   wire [17:0] tick_cnt_nxt = tick ? 18'h0 : 18'(tick_cnt_r + 18'h1);
   wire [15:0] code_one_nxt = channel_code(monitor_one_source_select_r, monitor_one_scale_r,
         monitor_output_method_r, rotation_direction_select_r, quantity_bus,
         encoder_is_incremental, encoder_is_20bit_inc, index_seen_r);
   wire [15:0] code_two_nxt = channel_code(monitor_two_source_select_r, monitor_two_scale_r,
         monitor_output_method_r, rotation_direction_select_r, quantity_bus,
         encoder_is_incremental, encoder_is_20bit_inc, index_seen_r);
   wire wr_go = aw_have_r && w_have_r && !bvalid_r;
   wire [7:0] wr_ofs = aw_addr_r[7:0];
   wire wr_hit = (aw_addr_r[31:8] == 24'h0) && (wr_ofs <= OFS_DIR) && (wr_ofs[1:0] == 2'h0);
   wire [7:0] rd_ofs = s_axi_araddr[7:0];
   wire rd_go = s_axi_arvalid && !rvalid_r;
   wire rd_hit = (s_axi_araddr[31:8] == 24'h0) && (rd_ofs <= OFS_OUT) && (rd_ofs[1:0] == 2'h0);
   logic [31:0] rd_word;

   always_comb begin
      unique case (rd_ofs)
         OFS_SRC1: rd_word = {27'h0, monitor_one_source_select_r};
         OFS_SCALE1: rd_word = monitor_one_scale_r;
         OFS_SRC2: rd_word = {27'h0, monitor_two_source_select_r};
         OFS_SCALE2: rd_word = monitor_two_scale_r;
         OFS_METHOD: rd_word = {30'h0, monitor_output_method_r};
         OFS_DIR: rd_word = {31'h0, rotation_direction_select_r};
         OFS_STATUS: rd_word = {30'h0, step_r != ST_IDLE, index_seen_r};
         OFS_OUT: rd_word = {dac_two_code_r, dac_one_code_r};
         default: rd_word = 32'h0;
      endcase
   end

   // Merges byte lanes of a write into an old register value.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
         input logic [3:0] s);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return m;
   endfunction

   wire [31:0] wr_word = merge(32'h0, w_data_r, w_strb_r);
   wire aw_take = s_axi_awvalid && !aw_have_r;
   wire w_take = s_axi_wvalid && !w_have_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 32'h0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= AXI_OKAY;
      end else begin
         if (aw_take) begin
            aw_addr_r <= s_axi_awaddr;
            aw_have_r <= 1'b1;
         end
         if (w_take) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            w_have_r <= 1'b1;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? AXI_OKAY : AXI_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         monitor_one_source_select_r <= 5'h0;
         monitor_one_scale_r <= 32'h0;
         monitor_two_source_select_r <= 5'h0;
         monitor_two_scale_r <= 32'h0;
         monitor_output_method_r <= METH_BIPOLAR;
         rotation_direction_select_r <= 1'b0;
      end else if (wr_go && wr_hit && w_strb_r[0]) begin
         unique case (wr_ofs)
            OFS_SRC1: monitor_one_source_select_r <= wr_word[4:0];
            OFS_SCALE1: monitor_one_scale_r <= merge(monitor_one_scale_r, w_data_r, w_strb_r);
            OFS_SRC2: monitor_two_source_select_r <= wr_word[4:0];
            OFS_SCALE2: monitor_two_scale_r <= merge(monitor_two_scale_r, w_data_r, w_strb_r);
            OFS_METHOD: monitor_output_method_r <= wr_word[1:0];
            OFS_DIR: rotation_direction_select_r <= wr_word[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= AXI_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_hit ? rd_word : 32'h0;
         rresp_r <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Index latch; cleared only by reset, since a later encoder swap needs a restart.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         index_seen_r <= 1'b0;
      end else if (index_pulse) begin
         index_seen_r <= 1'b1;
      end
   end

   // Channel codes are loaded in successive cycles, channel one first; both are computed every cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_r <= 18'h0;
         step_r <= ST_IDLE;
         dac_one_code_r <= 16'h0;
         dac_two_code_r <= 16'h0;
         dac_update_r <= 1'b0;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
         dac_update_r <= 1'b0;
         unique case (step_r)
            ST_IDLE: if (tick) step_r <= ST_CH1;
            ST_CH1: begin
               dac_one_code_r <= code_one_nxt;
               step_r <= ST_CH2;
            end
            ST_CH2: begin
               dac_two_code_r <= code_two_nxt;
               dac_update_r <= 1'b1;
               step_r <= ST_IDLE;
            end
            default: step_r <= ST_IDLE;
         endcase
      end
   end

   assign s_axi_awready = !aw_have_r;
   assign s_axi_wready = !w_have_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign dac_one_code = dac_one_code_r;
   assign dac_two_code = dac_two_code_r;
   assign dac_update = dac_update_r;
endmodule

// ===== sim/monitor_checker.sv
// Port assertions for the analog monitor: register bus answers and DAC refresh timing.
`timescale 1ns/1ps
module monitor_checker
   import monitor_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] dac_one_code,
   input wire logic [15:0] dac_two_code,
   input wire logic dac_update
);
   logic [17:0] cnt_r;
   logic seen_r;
   logic aw_bad_r;
   wire aw_bad = |s_axi_awaddr[31:5] || |s_axi_awaddr[1:0] || s_axi_awaddr[7:0] == OFS_STATUS
      || s_axi_awaddr[7:0] == OFS_OUT;
   wire ar_bad = |s_axi_araddr[31:5] || |s_axi_araddr[1:0];
   // The period check waits for a first pulse, since the count from reset is not a full period.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
         seen_r <= 1'b0;
         aw_bad_r <= 1'b0;
      end else begin
         cnt_r <= dac_update ? '0 : cnt_r + 18'h1;
         seen_r <= seen_r | dac_update;
         if (s_axi_awvalid && s_axi_awready) aw_bad_r <= aw_bad;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_DAC_PULSE: assert property (dac_update |=> !dac_update)
      else $error("dac_update longer than one cycle");
   AST_DAC_PERIOD: assert property (dac_update && seen_r |-> cnt_r == 18'(REFRESH_CYCLES - 1))
      else $error("refresh period wrong");
   AST_CH_ONE_LOAD: assert property ($changed(dac_one_code) |=> dac_update)
      else $error("channel one code moved outside refresh");
   AST_CH_TWO_LOAD: assert property ($changed(dac_two_code) |-> dac_update)
      else $error("channel two code moved outside refresh");
   AST_B_AFTER: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
      else $error("write answered before address and data taken");
   AST_B_RESP: assert property ($rose(s_axi_bvalid) |->
      s_axi_bresp == (aw_bad_r ? AXI_SLVERR : AXI_OKAY)) else $error("write response code wrong");
   AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_R_ERR: assert property (s_axi_arvalid && s_axi_arready && ar_bad |=>
      s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
endmodule
bind analog_monitor monitor_checker u_chk (.*);

// ===== sim/meter_model.sv
// Meter on the monitor connector: holds the codes of the latest refresh.
`timescale 1ns/1ps
module meter_model (
   input wire logic aclk,
   input wire logic dac_update,
   input wire logic [15:0] dac_one_code,
   input wire logic [15:0] dac_two_code,
   output logic [15:0] last_one,
   output logic [15:0] last_two
);
   // Sampling on the strobe only, so codes caught between the two loads are never seen.
   always_ff @(posedge aclk) begin
      if (dac_update) begin
         last_one <= dac_one_code;
         last_two <= dac_two_code;
      end
   end
endmodule

// ===== sim/test_analog_monitor.sv
// Self-checking bench comparing the analog monitor with a behavioural model.
`timescale 1ns/1ps
module test_analog_monitor;
   import monitor_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, encoder_is_incremental = 1'b0;
   logic encoder_is_20bit_inc = 1'b0, index_pulse = 1'b0;
   logic [(SRC_LAST+1)*32-1:0] quantity_bus = '0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
   logic [31:0] seed = 32'h53;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dac_update;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [15:0] dac_one_code, dac_two_code, seen_one, seen_two;
   int error_cnt = 0, total_checks = 0;
   int t_m[3] = '{0, 1, 2}, t_d[3] = '{0, 1, 0}, t_s1[3] = '{0, 3, 1}, t_c1[3] = '{0, 250, 0};
   int t_s2[3] = '{4, 17, 2}, t_c2[3] = '{0, 0, 100};
   analog_monitor u_dut (.*);
   meter_model u_meter (.aclk, .dac_update, .dac_one_code, .dac_two_code,
      .last_one(seen_one), .last_two(seen_two));
   initial begin
      forever #2.5 aclk = ~aclk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] model(int s, int c, int m, int r);
      longint g, v;
      case (s)
         0, 1, 2, 3, 14, 15: g = GAIN_SPEED;
         4, 10, 11, 12, 13: g = GAIN_PCT;
         5, 6, 7, 8: g = GAIN_PULSE;
         9: g = GAIN_BUS;
         19, 20: g = GAIN_TEMP;
         21: g = GAIN_REV;
         default: g = 0;
      endcase
      if (g == 0) return (m == 2) ? DAC_MID : 16'h0;
      if (c != 0) g = c;
      // Encoder temperature reads as zero volts without a 20-bit incremental encoder.
      v = (s == 19) ? 0 : longint'($signed(quantity_bus[s*32 +: 32]));
      if (r != 0 && s != 21) v = -v;
      v = v * DAC_MAX / (g * FULL_VOLTS);
      if (m == 2) v = v / 2;
      if (v > DAC_MAX) v = DAC_MAX;
      if (v < DAC_MIN) v = DAC_MIN;
      if (m == 1) return 16'((v < 0 ? -v : v) * 2);
      if (m == 2) return 16'(v + longint'(DAC_MID));
      return 16'(v);
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic tmo(string n);
      error_cnt++;
      $display("mismatch %s expected answer seen timeout", n);
      print_verdict();
   endtask
   task automatic cmp_reg(string n, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp_resp(string n, logic [1:0] e, logic [1:0] g);
      cmp_reg(n, {30'h0, e}, {30'h0, g});
   endtask
   task automatic cmp_dac(string n, logic [15:0] e, logic [15:0] g);
      cmp_reg(n, {16'h0, e}, {16'h0, g});
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 64);
      if (n >= 64) tmo("bvalid");
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 64);
      if (n >= 64) tmo("rvalid");
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   initial begin
      int n;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         axr(8'(i * 4));
         cmp_reg("setting after reset", 32'h0, rd);
         cmp_resp("read response", AXI_OKAY, resp);
      end
      axr(8'h20);
      cmp_resp("unmapped read response", AXI_SLVERR, resp);
      axw(OFS_STATUS, 32'h1);
      cmp_resp("status write response", AXI_SLVERR, resp);
      axw(OFS_SCALE2, 32'hA5C3);
      axr(OFS_SCALE2);
      cmp_reg("scale readback", 32'hA5C3, rd);
      $display("test registers done");
      for (int t = 0; t < 3; t++) begin
         for (int k = 0; k < 22; k++) quantity_bus[k*32 +: 32] <= xs() % 32'h4E21 - 32'h2710;
         axw(OFS_METHOD, 32'(t_m[t]));
         axw(OFS_DIR, 32'(t_d[t]));
         axw(OFS_SRC1, 32'(t_s1[t]));
         axw(OFS_SCALE1, 32'(t_c1[t]));
         axw(OFS_SRC2, 32'(t_s2[t]));
         axw(OFS_SCALE2, 32'(t_c2[t]));
         n = 0;
         do begin
            @(posedge aclk);
            n++;
         end while (!dac_update && n < 250000);
         if (n >= 250000) tmo("dac_update");
         #1;
         cmp_dac("channel one", model(t_s1[t], t_c1[t], t_m[t], t_d[t]), seen_one);
         cmp_dac("channel two", model(t_s2[t], t_c2[t], t_m[t], t_d[t]), seen_two);
         $display("test refresh %0d done", t);
      end
      print_verdict();
   end
endmodule
